/* File: usdp_datapath.sv */
/*
  Transmit and receive data paths of a serial port, registers on APB.
  Assumes a single 100 MHz clock, synchronous pins, and a core that services interrupts.
*/
// Functional notes
// - Transmitter enable makes the block drive the serial output pin.
// - Data write fills the buffer; it moves to the shifter when idle or after stop.
// - The shifter sends one frame at the divider rate or the external clock.
// - Below eight bits, upper data bits written are ignored.
// - Nine-bit size takes bit eight from the ninth-bit control; software sets it first.
// - Empty flag is high when the buffer is empty, low while it holds data.
// - A write to the data register clears the empty flag.
// - Buffer-empty interrupt requests as long as flag and enable are high.
// - Transmit-complete sets when the frame is out and the buffer is empty.
// - Transmit-complete clears on interrupt service or a written one.
// - Transmit-complete interrupt requests when the flag and enable are high.
// - With parity enabled a parity bit follows the last data bit.
// - Clearing transmitter enable waits until shifter and buffer are done.
// - Receiver enable makes the block use the serial input pin.
// - Synchronous mode clocks bits by the external clock pin.
// - Receiver starts on a valid start bit and shifts bits to the first stop.
// - The receiver ignores any second stop bit.
// - After the first stop bit the shifter moves into the receive buffer.
// - Short characters read back with zero upper bits.
// - Frame is low start, data LSB first, optional parity, high stops.
// - Parity is the xor of data bits, inverted for odd parity.
// - Receive-complete is high while unread data sit in the receive buffer.
// - Clearing receiver enable stops reception and flushes the buffer at once.
`timescale 1ns/1ps
`include "usdp_defs.svh"

module usdp_datapath (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rxd_in,
  input  wire logic        xck_in,
  input  wire logic        data_register_empty_flag_ack,
  input  wire logic        txc_ack,
  output logic             txd_out,
  output logic             txd_oe,
  output logic             rxd_owned,
  output logic             irq_data_register_empty_flag,
  output logic             irq_txc,
  output logic             irq_rxc
);

  usdp_pkg::usdp_state_t s_r;
  usdp_pkg::usdp_state_t s_nxt;
  logic [7:0] err_r;

  logic       acc;
  logic       wr;
  logic       rd;
  logic [3:0] nbits;
  logic [8:0] dmask;
  logic       sync_m;
  logic       bit_tick;
  logic       xrise;
  logic       xfall;
  logic       rx_bit;
  logic [4:0] ovs;

  always_comb begin
    acc    = psel && penable && !s_r.pready;
    wr     = acc && pwrite;
    rd     = acc && !pwrite;
    // Size codes three to six all read as eight bits, so the reset format gives eight-bit characters.
    nbits  = (s_r.format[2:0] == `USDP_SIZE_NINE) ? 4'h9 :
             (s_r.format[2:0] > 3'h2) ? 4'h8 : (4'h5 + {2'h0, s_r.format[1:0]});
    dmask  = 9'h1FF >> (4'h9 - nbits);
    sync_m = s_r.format[`USDP_FM_SYNC];
    ovs    = s_r.status[`USDP_ST_U2X] ? `USDP_OVS_DOUBLE : `USDP_OVS_NORMAL;
    bit_tick = (s_r.bdiv == 12'h000);
    xrise  = s_r.xck_s && !s_r.xck_d;
    xfall  = !s_r.xck_s && s_r.xck_d;
    rx_bit = s_r.control[`USDP_CT_RECEIVER_ENABLE_BIT] ? rxd_in : 1'b1;
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.pready = acc;
    s_nxt.xck_s  = xck_in;
    s_nxt.xck_d  = s_r.xck_s;
    s_nxt.bdiv   = bit_tick ? s_r.baud : s_r.bdiv - 12'h001;

    if (rd) begin
      case (paddr)
        `USDP_OFS_DATA: begin
          s_nxt.prdata = {24'h0, s_r.rxbuf[7:0] & dmask[7:0]};
          s_nxt.rxbuf_full = 1'b0;
        end
        `USDP_OFS_STATUS:  s_nxt.prdata = {24'h0, s_r.status};
        `USDP_OFS_CONTROL: s_nxt.prdata = {24'h0, s_r.control};
        `USDP_OFS_FORMAT:  s_nxt.prdata = {24'h0, s_r.format};
        `USDP_OFS_BAUD:    s_nxt.prdata = {20'h0, s_r.baud};
        `USDP_OFS_RXNINTH: s_nxt.prdata = {31'h0, s_r.rxbuf[8] & dmask[8]};
        default:           s_nxt.prdata = 32'h0;
      endcase
    end

    if (wr) begin
      case (paddr)
        `USDP_OFS_DATA: begin
          s_nxt.txbuf = {s_r.control[`USDP_CT_TRANSMIT_NINTH_BIT], pwdata[7:0]} & dmask;
          s_nxt.txbuf_full = 1'b1;
        end
        `USDP_OFS_STATUS: begin
          s_nxt.status[`USDP_ST_U2X] = pwdata[`USDP_ST_U2X];
          if (pwdata[`USDP_ST_TXC])
            s_nxt.status[`USDP_ST_TXC] = 1'b0;
        end
        `USDP_OFS_CONTROL: s_nxt.control = pwdata[7:0];
        `USDP_OFS_FORMAT:  s_nxt.format  = pwdata[7:0];
        `USDP_OFS_BAUD:    s_nxt.baud    = pwdata[11:0];
        default: ;
      endcase
    end
    if (txc_ack)
      s_nxt.status[`USDP_ST_TXC] = 1'b0;

    // Transmitter; ticks are divider ticks (oversampled) or rising EXTERNAL_BIT_CLOCK_PIN edges.
    if (sync_m ? xrise : bit_tick)
      s_nxt.tx_tick = s_r.tx_tick + 5'h01;
    case (s_r.tx_ph)
      usdp_pkg::USDP_PH_IDLE: begin
        s_nxt.txd = 1'b1;
        // A buffered word still goes out after the enable was cleared, as long as the pin is held.
        if (s_r.txbuf_full && (s_r.control[`USDP_CT_TRANSMITTER_ENABLE_BIT] || s_r.tx_own)) begin
          s_nxt.txsh = s_r.txbuf;
          s_nxt.txbuf_full = wr && paddr == `USDP_OFS_DATA;
          s_nxt.tx_par = s_r.format[`USDP_FM_UPM0] ^ (^s_r.txbuf);
          s_nxt.tx_ph = usdp_pkg::USDP_PH_START;
          s_nxt.tx_tick = 5'h00;
          s_nxt.txd = 1'b0;
        end
      end
      usdp_pkg::USDP_PH_START, usdp_pkg::USDP_PH_DATA, usdp_pkg::USDP_PH_PAR,
      usdp_pkg::USDP_PH_STOP: begin
        if ((sync_m ? xfall : (bit_tick && s_r.tx_tick == ovs - 5'h01))) begin
          s_nxt.tx_tick = 5'h00;
          case (s_r.tx_ph)
            usdp_pkg::USDP_PH_START: begin
              s_nxt.tx_ph = usdp_pkg::USDP_PH_DATA;
              s_nxt.tx_cnt = 4'h1;
              s_nxt.txd = s_r.txsh[0];
              s_nxt.txsh = s_r.txsh >> 1;
            end
            usdp_pkg::USDP_PH_DATA: begin
              if (s_r.tx_cnt == nbits) begin
                if (s_r.format[`USDP_FM_PARITY_ENABLE_BIT]) begin
                  s_nxt.tx_ph = usdp_pkg::USDP_PH_PAR;
                  s_nxt.txd = s_r.tx_par;
                end else begin
                  s_nxt.tx_ph = usdp_pkg::USDP_PH_STOP;
                  s_nxt.txd = 1'b1;
                  s_nxt.tx_stop2 = s_r.format[`USDP_FM_USBS];
                end
              end else begin
                s_nxt.tx_cnt = s_r.tx_cnt + 4'h1;
                s_nxt.txd = s_r.txsh[0];
                s_nxt.txsh = s_r.txsh >> 1;
              end
            end
            usdp_pkg::USDP_PH_PAR: begin
              s_nxt.tx_ph = usdp_pkg::USDP_PH_STOP;
              s_nxt.txd = 1'b1;
              s_nxt.tx_stop2 = s_r.format[`USDP_FM_USBS];
            end
            default: begin
              if (s_r.tx_stop2) begin
                s_nxt.tx_stop2 = 1'b0;
              end else if (s_r.txbuf_full) begin
                s_nxt.txsh = s_r.txbuf;
                s_nxt.txbuf_full = wr && paddr == `USDP_OFS_DATA;
                s_nxt.tx_par = s_r.format[`USDP_FM_UPM0] ^ (^s_r.txbuf);
                s_nxt.tx_ph = usdp_pkg::USDP_PH_START;
                s_nxt.txd = 1'b0;
              end else begin
                s_nxt.tx_ph = usdp_pkg::USDP_PH_IDLE;
                s_nxt.status[`USDP_ST_TXC] = 1'b1;
              end
            end
          endcase
        end
      end
      default: s_nxt.tx_ph = usdp_pkg::USDP_PH_IDLE;
    endcase
    // Pin is kept until both shifter and buffer are drained.
    s_nxt.tx_own = s_r.control[`USDP_CT_TRANSMITTER_ENABLE_BIT] ||
                   (s_r.tx_own && (s_r.tx_ph != usdp_pkg::USDP_PH_IDLE || s_r.txbuf_full));
    s_nxt.status[`USDP_ST_DATA_REGISTER_EMPTY_FLAG] = !s_nxt.txbuf_full;

    // Receiver; asynchronous mode samples at mid-bit of the oversampled grid.
    if (bit_tick && !sync_m)
      s_nxt.rx_tick = s_r.rx_tick + 5'h01;
    case (s_r.rx_ph)
      usdp_pkg::USDP_PH_IDLE: begin
        if (!rx_bit && s_r.control[`USDP_CT_RECEIVER_ENABLE_BIT]) begin
          s_nxt.rx_ph = usdp_pkg::USDP_PH_START;
          s_nxt.rx_tick = 5'h00;
          s_nxt.rx_cnt = 4'h0;
        end
      end
      usdp_pkg::USDP_PH_START: begin
        if (sync_m ? xfall : (bit_tick && s_r.rx_tick == (ovs >> 1) - 5'h01)) begin
          s_nxt.rx_tick = 5'h00;
          s_nxt.rx_ph = rx_bit ? usdp_pkg::USDP_PH_IDLE : usdp_pkg::USDP_PH_DATA;
        end
      end
      usdp_pkg::USDP_PH_DATA, usdp_pkg::USDP_PH_PAR, usdp_pkg::USDP_PH_STOP: begin
        if (sync_m ? xfall : (bit_tick && s_r.rx_tick == ovs - 5'h01)) begin
          s_nxt.rx_tick = 5'h00;
          if (s_r.rx_ph == usdp_pkg::USDP_PH_DATA) begin
            s_nxt.rxsh = {rx_bit, s_r.rxsh[8:1]};
            s_nxt.rx_cnt = s_r.rx_cnt + 4'h1;
            if (s_r.rx_cnt + 4'h1 == nbits)
              s_nxt.rx_ph = s_r.format[`USDP_FM_PARITY_ENABLE_BIT] ? usdp_pkg::USDP_PH_PAR : usdp_pkg::USDP_PH_STOP;
          end else if (s_r.rx_ph == usdp_pkg::USDP_PH_PAR) begin
            s_nxt.rx_ph = usdp_pkg::USDP_PH_STOP;
          end else begin
            s_nxt.rx_ph = usdp_pkg::USDP_PH_IDLE;
            s_nxt.rxbuf = (s_r.rxsh >> (4'h9 - nbits)) & dmask;
            s_nxt.rxbuf_full = 1'b1;
          end
        end
      end
      default: s_nxt.rx_ph = usdp_pkg::USDP_PH_IDLE;
    endcase
    if (!s_r.control[`USDP_CT_RECEIVER_ENABLE_BIT]) begin
      s_nxt.rx_ph = usdp_pkg::USDP_PH_IDLE;
      s_nxt.rxbuf_full = 1'b0;
    end
    s_nxt.status[`USDP_ST_RXC] = s_nxt.rxbuf_full;

    s_nxt.irq_data_register_empty_flag = s_nxt.status[`USDP_ST_DATA_REGISTER_EMPTY_FLAG] && s_nxt.control[`USDP_CT_BUFFER_EMPTY_IRQ_ENABLE];
    s_nxt.irq_txc  = s_nxt.status[`USDP_ST_TXC] && s_nxt.control[`USDP_CT_TRANSMIT_COMPLETE_IRQ_ENABLE];
    s_nxt.irq_rxc  = s_nxt.status[`USDP_ST_RXC];
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_r <= '0;
      s_r.status[`USDP_ST_DATA_REGISTER_EMPTY_FLAG] <= 1'b1;
      s_r.format <= `USDP_FORMAT_RST;
      s_r.baud <= `USDP_BAUD_RST;
      s_r.txd <= 1'b1;
      err_r <= 8'h00;
    end else if (clk_en) begin
      s_r <= s_nxt;
      err_r <= {7'h0, acc && pslv_bad(paddr)};
    end
  end

  function automatic logic pslv_bad(input logic [7:0] a);
    pslv_bad = a > `USDP_OFS_RXNINTH || a[1:0] != 2'h0;
  endfunction : pslv_bad

  always_comb begin
    prdata    = s_r.prdata;
    pready    = s_r.pready;
    pslverr   = err_r[0];
    txd_out   = s_r.txd;
    txd_oe    = s_r.tx_own;
    rxd_owned = s_r.control[`USDP_CT_RECEIVER_ENABLE_BIT];
    irq_data_register_empty_flag  = s_r.irq_data_register_empty_flag;
    irq_txc   = s_r.irq_txc;
    irq_rxc   = s_r.irq_rxc;
  end

  data_register_empty_flag_level_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en |=> (irq_data_register_empty_flag == $past(s_nxt.status[`USDP_ST_DATA_REGISTER_EMPTY_FLAG] && s_nxt.control[`USDP_CT_BUFFER_EMPTY_IRQ_ENABLE])))
    else $error("buffer-empty request wrong");
  sequence data_write_s;
    wr && paddr == `USDP_OFS_DATA && clk_en;
  endsequence
  write_clears_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    data_write_s |=> !s_r.status[`USDP_ST_DATA_REGISTER_EMPTY_FLAG])
    else $error("empty flag not cleared by write");
  empty_track_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_r.status[`USDP_ST_DATA_REGISTER_EMPTY_FLAG] == !s_r.txbuf_full)
    else $error("empty flag mismatch");
  start_low_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_r.tx_ph == usdp_pkg::USDP_PH_START |-> !s_r.txd)
    else $error("start bit not low");
  idle_high_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_r.tx_ph == usdp_pkg::USDP_PH_IDLE && $past(s_r.tx_ph) == usdp_pkg::USDP_PH_IDLE |-> s_r.txd)
    else $error("idle line not high");
  tx_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_r.tx_ph != usdp_pkg::USDP_PH_IDLE |-> s_r.tx_own)
    else $error("pin released mid frame");
  rx_flush_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en && !s_r.control[`USDP_CT_RECEIVER_ENABLE_BIT] |=> !s_r.rxbuf_full && s_r.rx_ph == usdp_pkg::USDP_PH_IDLE)
    else $error("receiver not flushed");
  rxc_track_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_r.status[`USDP_ST_RXC] == s_r.rxbuf_full)
    else $error("receive flag mismatch");
  txc_set_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en && s_r.tx_ph == usdp_pkg::USDP_PH_STOP && s_nxt.tx_ph == usdp_pkg::USDP_PH_IDLE
    |=> s_r.status[`USDP_ST_TXC])
    else $error("complete flag not set");
  txc_clear_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en && txc_ack && !(s_r.tx_ph == usdp_pkg::USDP_PH_STOP && s_nxt.tx_ph == usdp_pkg::USDP_PH_IDLE)
    |=> !s_r.status[`USDP_ST_TXC])
    else $error("complete flag not cleared");

endmodule : usdp_datapath

/* File: usdp_defs.svh */
/*
  Offsets, field positions, reset values and timing counts of the serial data path.
  Assumes inclusion by bare name from the testbench and the design module.
*/
`ifndef USDP_DEFS_SVH
`define USDP_DEFS_SVH

`define USDP_OFS_DATA     8'h00
`define USDP_OFS_STATUS   8'h04
`define USDP_OFS_CONTROL  8'h08
`define USDP_OFS_FORMAT   8'h0C
`define USDP_OFS_BAUD     8'h10
`define USDP_OFS_RXNINTH  8'h14

`define USDP_ST_RXC       7
`define USDP_ST_TXC       6
`define USDP_ST_DATA_REGISTER_EMPTY_FLAG      5
`define USDP_ST_U2X       1

`define USDP_CT_RECEIVER_ENABLE_BIT      4
`define USDP_CT_TRANSMITTER_ENABLE_BIT      3
`define USDP_CT_BUFFER_EMPTY_IRQ_ENABLE     5
`define USDP_CT_TRANSMIT_COMPLETE_IRQ_ENABLE     6
`define USDP_CT_TRANSMIT_NINTH_BIT      0

`define USDP_FM_SYNC      6
`define USDP_FM_PARITY_ENABLE_BIT      5
`define USDP_FM_UPM0      4
`define USDP_FM_USBS      3
`define USDP_FM_SIZE_LO   0

`define USDP_SIZE_NINE    3'h7
`define USDP_FORMAT_RST   8'h06
`define USDP_BAUD_RST     12'h000
`define USDP_OVS_NORMAL   5'h10
`define USDP_OVS_DOUBLE   5'h08

`endif

/* File: usdp_pkg.sv */
/*
  Types of the serial data path: transmit and receive phases and the state record.
  Assumes usdp_defs.svh is reachable by bare name.
*/
package usdp_pkg;
  typedef enum logic [2:0] {
    USDP_PH_IDLE,
    USDP_PH_START,
    USDP_PH_DATA,
    USDP_PH_PAR,
    USDP_PH_STOP
  } usdp_phase_t;

  typedef struct packed {
    logic [7:0]  status;
    logic [7:0]  control;
    logic [7:0]  format;
    logic [11:0] baud;
    logic [8:0]  txbuf;
    logic        txbuf_full;
    logic [8:0]  txsh;
    usdp_phase_t tx_ph;
    logic [3:0]  tx_cnt;
    logic [4:0]  tx_tick;
    logic        tx_par;
    logic        tx_stop2;
    logic        tx_own;
    logic        txd;
    logic [8:0]  rxsh;
    usdp_phase_t rx_ph;
    logic [3:0]  rx_cnt;
    logic [4:0]  rx_tick;
    logic [8:0]  rxbuf;
    logic        rxbuf_full;
    logic [11:0] bdiv;
    logic        xck_s;
    logic        xck_d;
    logic        irq_data_register_empty_flag;
    logic        irq_txc;
    logic        irq_rxc;
    logic [31:0] prdata;
    logic        pready;
  } usdp_state_t;
endpackage : usdp_pkg

/* File: usdp_far_end.sv */
/*
  Far-end serial transceiver model: sends frames on the receive line, decodes the transmit line.
  Assumes 16 clocks per bit (divider zero, normal speed) and an idle-high line.
*/
`timescale 1ns/1ps
module usdp_far_end #(
  parameter int BIT = 16
) (
  input  wire logic       core_clk,
  input  wire logic       line_in,
  input  wire logic [3:0] nb,
  input  wire logic       pe,
  output logic            rxd
);
  logic [9:0] q [$];
  logic [8:0] w;
  logic       p;

  initial rxd = 1'b1;

  task automatic send(input logic [8:0] v, input int n);
    rxd <= 1'b0;
    repeat (BIT) @(posedge core_clk);
    for (int i = 0; i < n; i++) begin
      rxd <= v[i];
      repeat (BIT) @(posedge core_clk);
    end
    rxd <= 1'b1;
    repeat (BIT) @(posedge core_clk);
  endtask : send

  // Sampling mid-bit leaves half a bit of slack for where the sender places its edges.
  always begin
    @(negedge line_in);
    w = '0;
    p = 1'b0;
    repeat (BIT / 2) @(posedge core_clk);
    for (int i = 0; i < nb; i++) begin
      repeat (BIT) @(posedge core_clk);
      w[i] = line_in;
    end
    if (pe) begin
      repeat (BIT) @(posedge core_clk);
      p = line_in;
    end
    repeat (BIT) @(posedge core_clk);
    q.push_back({p, w});
  end
endmodule : usdp_far_end

/* File: testbench.sv */
/*
  Self-checking bench of the serial data path: APB master, far-end model, scenarios.
  Assumes the divider stays at its reset value, so one bit lasts 16 clocks.
*/
`timescale 1ns/1ps
`include "usdp_defs.svh"
module testbench;
  logic        core_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        txc_ack = 1'b0;
  logic        external_bit_clock_pin = 1'b0;
  logic [31:0] prdata, q;
  logic        pready, pslverr, err, txd_out, txd_oe, rxd_owned, rxd, line;
  logic        irq_data_register_empty_flag, irq_txc, irq_rxc;
  logic [3:0]  nb = 4'h8;
  logic        pe = 1'b0;
  logic [2:0]  flags;
  int          errors = 0;
  int          num_checks = 0;
  int          cyc = 0;
  localparam logic [7:0] FM [4] = '{8'h30, 8'h21, 8'h02, 8'h07};
  localparam logic [7:0] DV [4] = '{8'hFF, 8'h2B, 8'hFF, 8'h3C};
  localparam logic [8:0] EX [4] = '{9'h01F, 9'h02B, 9'h07F, 9'h13C};

  always #5 core_clk = ~core_clk;
  assign line = txd_oe ? txd_out : 1'b1;
  assign flags = {irq_rxc, irq_txc, irq_data_register_empty_flag};

  usdp_datapath u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxd_in(rxd), .xck_in(external_bit_clock_pin), .data_register_empty_flag_ack(1'b0),
    .txc_ack(txc_ack), .txd_out(txd_out), .txd_oe(txd_oe), .rxd_owned(rxd_owned),
    .irq_data_register_empty_flag(irq_data_register_empty_flag), .irq_txc(irq_txc), .irq_rxc(irq_rxc));
  usdp_far_end u_far (.core_clk(core_clk), .line_in(line), .nb(nb), .pe(pe), .rxd(rxd));

  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    chk(pready, 1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb

  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : rd

  task wt(input int i);
    int n;
    n = 0;
    while (flags[i] !== 1'b1 && n < 900) begin
      @(posedge core_clk);
      n++;
    end
    chk(flags[i], 1);
  endtask : wt

  task t_reset;
    rd(`USDP_OFS_STATUS, 32'h20);
    rd(`USDP_OFS_FORMAT, 32'h06);
    chk(txd_oe, 0);
    rd(8'h40, 32'h0);
    chk(err, 1);
  endtask : t_reset

  task t_tx8;
    apb(1'b1, `USDP_OFS_CONTROL, 32'h48);
    chk(txd_oe, 1);
    apb(1'b1, `USDP_OFS_DATA, 32'hA5);
    apb(1'b1, `USDP_OFS_DATA, 32'h3C);
    rd(`USDP_OFS_STATUS, 32'h0);
    apb(1'b1, `USDP_OFS_CONTROL, 32'h68);
    chk(irq_data_register_empty_flag, 0);
    wt(0);
    wt(1);
    chk(u_far.q.pop_front(), 10'h0A5);
    chk(u_far.q.pop_front(), 10'h03C);
    apb(1'b1, `USDP_OFS_STATUS, 32'h0);
    chk(irq_txc, 1);
    apb(1'b1, `USDP_OFS_STATUS, 32'h40);
    chk(irq_txc, 0);
    apb(1'b1, `USDP_OFS_CONTROL, 32'h48);
    apb(1'b1, `USDP_OFS_DATA, 32'h55);
    wt(1);
    txc_ack <= 1'b1;
    @(posedge core_clk);
    txc_ack <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk(irq_txc, 0);
    void'(u_far.q.pop_front());
    apb(1'b1, `USDP_OFS_DATA, 32'hC3);
    apb(1'b1, `USDP_OFS_CONTROL, 32'h40);
    chk(txd_oe, 1);
    wt(1);
    repeat (4) @(posedge core_clk);
    chk(txd_oe, 0);
    chk(u_far.q.pop_front(), 10'h0C3);
  endtask : t_tx8

  task t_fmt;
    for (int i = 0; i < 4; i++) begin
      nb <= (FM[i][2:0] == 3'h7) ? 4'h9 : 4'h5 + {1'b0, FM[i][2:0]};
      pe <= FM[i][5];
      apb(1'b1, `USDP_OFS_FORMAT, {24'h0, FM[i]});
      apb(1'b1, `USDP_OFS_CONTROL, {31'h24, FM[i][0]});
      apb(1'b1, `USDP_OFS_STATUS, 32'h40);
      apb(1'b1, `USDP_OFS_DATA, {24'h0, DV[i]});
      wt(1);
      chk(u_far.q.pop_front(), {FM[i][5] & (^EX[i] ^ FM[i][4]), EX[i]});
    end
  endtask : t_fmt

  task t_rx;
    nb <= 4'h8;
    pe <= 1'b0;
    apb(1'b1, `USDP_OFS_FORMAT, 32'h0E);
    apb(1'b1, `USDP_OFS_CONTROL, 32'h10);
    chk(rxd_owned, 1);
    fork
      begin
        u_far.send(9'h05A, 8);
        u_far.send(9'h0C3, 8);
      end
    join_none
    wt(2);
    rd(`USDP_OFS_DATA, 32'h5A);
    wt(2);
    rd(`USDP_OFS_DATA, 32'hC3);
    chk(irq_rxc, 0);
    apb(1'b1, `USDP_OFS_FORMAT, 32'h00);
    u_far.send(9'h1FF, 5);
    wt(2);
    rd(`USDP_OFS_DATA, 32'h1F);
    u_far.send(9'h011, 5);
    wt(2);
    apb(1'b1, `USDP_OFS_CONTROL, 32'h00);
    chk(rxd_owned, 0);
    chk(irq_rxc, 0);
    apb(1'b1, `USDP_OFS_CONTROL, 32'h10);
    rd(`USDP_OFS_STATUS, 32'h60);
    // Synchronous reception: the bit clock falls three quarters of the way into each bit sent by the far end.
    apb(1'b1, `USDP_OFS_FORMAT, 32'h4E);
    fork
      begin
        repeat (4) @(posedge core_clk);
        repeat (40) begin
          external_bit_clock_pin <= ~external_bit_clock_pin;
          repeat (8) @(posedge core_clk);
        end
      end
    join_none
    u_far.send(9'h0A6, 8);
    wt(2);
    rd(`USDP_OFS_DATA, 32'hA6);
  endtask : t_rx

  task wrap_up;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up

  // The ceiling allows roughly ten times the frames the scenarios send.
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      wrap_up;
    end
  end

  initial begin
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    t_reset;
    t_tx8;
    t_fmt;
    t_rx;
    wrap_up;
  end
endmodule : testbench
